// ### src/pcdc_top.sv
`timescale 1ns/1ps
`include "pcdc_cfg.svh"
// Overview of operation
// - Target claims only I/O, config, memory read.
// - Initiator issues only four memory operations.
// - Never initiator and target at once.
// - Wins bus and finishes memory access alone.
// - Forwarded disk accesses use the target role.
// - Only Type 0 configuration cycles answered.
// - Register index comes from address bits 7:2.
// - Index above 15 reads zero, ignores writes.
// - Hardware reset clears all writable config bits.
// - After reset only configuration cycles claimed.
// - Writes to reserved bits change nothing.
// - Reserved bits read as zero.
// - Class register holds class, subclass, interface.
// - Request asserted while wanting the bus.
module pcdc_top #(
	parameter logic [31:0] ID_VALUE = 32'h0001_0002, // Arbitrary identity value.
	parameter logic [7:0] CLASS_BASE = 8'h01,
	parameter logic [7:0] CLASS_SUB = 8'h01,
	parameter logic [7:0] CLASS_PROGIF = 8'h8f,
	parameter logic [7:0] REVISION = 8'h01 // Arbitrary revision value.
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic hardware_reset_in_n,
	input wire logic [31:0] ad_in,
	output logic [31:0] ad_out,
	output logic ad_oe,
	input wire logic [3:0] cbe_n_in,
	output logic [3:0] cbe_n_out,
	output logic cbe_oe,
	input wire logic frame_n_in,
	output logic frame_n_out,
	output logic frame_oe,
	input wire logic irdy_n_in,
	output logic irdy_n_out,
	output logic irdy_oe,
	input wire logic trdy_n_in,
	output logic trdy_n_out,
	output logic trdy_oe,
	input wire logic devsel_n_in,
	output logic devsel_n_out,
	output logic devsel_oe,
	output logic stop_n_out,
	output logic stop_oe,
	input wire logic idsel,
	input wire logic gnt_n,
	output logic req_n,
	output logic fwd_req,
	output logic fwd_write,
	output logic fwd_is_io,
	output logic [31:0] fwd_addr,
	output logic [31:0] fwd_wdata,
	output logic [3:0] fwd_be,
	input wire logic fwd_ack,
	input wire logic [31:0] fwd_rdata,
	input wire logic mst_start,
	input wire pcdc_pkg::pcdc_op_t mst_op,
	input wire logic [31:0] mst_addr,
	input wire logic [31:0] mst_wdata,
	output logic mst_busy,
	output logic mst_done,
	output logic mst_error,
	output logic [31:0] mst_rdata,
	output logic [2:0] enables
);
	import pcdc_pkg::*;
	localparam int ABORT_CYC = `PCDC_ABORT_CYC;

	// Pins are asynchronous to clk; everything below reads only the second stage.
	logic [42:0] sync1_q, sync2_q;
	logic frame_prev_q;
	always_ff @(posedge clk) begin
		sync1_q <= {hardware_reset_in_n, frame_n_in, irdy_n_in, trdy_n_in, devsel_n_in,
			gnt_n, idsel, cbe_n_in, ad_in};
		sync2_q <= sync1_q;
		frame_prev_q <= sync2_q[41];
	end
	logic hw_s, frame_s, irdy_s, trdy_s, devsel_s, gnt_s, idsel_s;
	logic [3:0] cbe_s;
	logic [31:0] ad_s;
	assign {hw_s, frame_s, irdy_s, trdy_s, devsel_s, gnt_s, idsel_s, cbe_s, ad_s} = sync2_q;
	wire frame_fall = frame_prev_q && !frame_s;

	// Configuration space storage and the read view of it.
	logic [2:0] ctrl_q, ctrl_d;
	logic [31:`PCDC_IOBAR_LSB] iobar_q, iobar_d;
	logic [31:`PCDC_MEMBAR_LSB] membar_q, membar_d;
	logic [7:0] intline_q, intline_d;
	function automatic logic [31:0] cfg_read(input logic [5:0] idx);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (idx[5:4] == 2'b00) begin
			unique case (idx[3:0])
				`PCDC_IDX_ID: v = ID_VALUE;
				`PCDC_IDX_CTRL: v = {29'h0000_0000, ctrl_q};
				`PCDC_IDX_CLASS: v = {CLASS_BASE, CLASS_SUB, CLASS_PROGIF, REVISION};
				`PCDC_IDX_IOBAR: v = {iobar_q, 4'h1};
				`PCDC_IDX_MEMBAR: v = {membar_q, 12'h000};
				`PCDC_IDX_INTLINE: v = {24'h00_0000, intline_q};
				default: v = 32'h0000_0000;
			endcase
		end
		return v;
	endfunction

	// Target side.
	pcdc_tst_t t_q, t_d;
	pcdc_mst_t m_q, m_d;
	logic [3:0] lop_q, lop_d;
	logic [31:0] laddr_q, laddr_d, t_ad;
	logic t_ad_en, claim_d, trdy_d, stop_d;
	logic fwd_req_q, fwd_req_d, fwd_write_q, fwd_write_d, fwd_io_q, fwd_io_d;
	logic [31:0] fwd_wdata_q, fwd_wdata_d;
	logic [3:0] fwd_be_q, fwd_be_d;
	logic cfg_hit, io_hit, mem_hit;
	always_comb begin
		t_d = t_q;
		lop_d = lop_q;
		laddr_d = laddr_q;
		t_ad = 32'h0000_0000;
		t_ad_en = 1'b0;
		trdy_d = 1'b0;
		stop_d = 1'b0;
		fwd_req_d = 1'b0;
		fwd_write_d = fwd_write_q;
		fwd_io_d = fwd_io_q;
		fwd_wdata_d = fwd_wdata_q;
		fwd_be_d = fwd_be_q;
		ctrl_d = ctrl_q;
		iobar_d = iobar_q;
		membar_d = membar_q;
		intline_d = intline_q;
		cfg_hit = idsel_s && (ad_s[1:0] == 2'b00) &&
			(cbe_s == OP_CFG_RD || cbe_s == OP_CFG_WR);
		io_hit = ctrl_q[`PCDC_CTRL_IO_EN] && (cbe_s == OP_IO_RD || cbe_s == OP_IO_WR) &&
			(ad_s[31:`PCDC_IOBAR_LSB] == iobar_q);
		mem_hit = ctrl_q[`PCDC_CTRL_MEM_EN] && (cbe_s == OP_MEM_RD) &&
			(ad_s[31:`PCDC_MEMBAR_LSB] == membar_q);
		unique case (t_q)
			T_IDLE: begin
				// Our own frame is ignored, so target and initiator never overlap.
				if (frame_fall && m_q == M_IDLE) begin
					lop_d = cbe_s;
					laddr_d = ad_s;
					if (cfg_hit) begin
						t_d = T_CFG;
					end else if (io_hit || mem_hit) begin
						t_d = T_FWD;
					end
				end
			end
			T_CFG: begin
				if (!irdy_s) begin
					t_d = T_END;
					trdy_d = 1'b1;
					stop_d = !frame_s;
					if (lop_q == OP_CFG_RD) begin
						t_ad = cfg_read(laddr_q[7:2]);
						t_ad_en = 1'b1;
					end else if (laddr_q[7:6] == 2'b00) begin
						unique case (laddr_q[5:2])
							`PCDC_IDX_CTRL: if (!cbe_s[0]) ctrl_d = ad_s[2:0];
							`PCDC_IDX_IOBAR: begin
								if (!cbe_s[0]) iobar_d[7:4] = ad_s[7:4];
								if (!cbe_s[1]) iobar_d[15:8] = ad_s[15:8];
								if (!cbe_s[2]) iobar_d[23:16] = ad_s[23:16];
								if (!cbe_s[3]) iobar_d[31:24] = ad_s[31:24];
							end
							`PCDC_IDX_MEMBAR: begin
								if (!cbe_s[1]) membar_d[15:12] = ad_s[15:12];
								if (!cbe_s[2]) membar_d[23:16] = ad_s[23:16];
								if (!cbe_s[3]) membar_d[31:24] = ad_s[31:24];
							end
							`PCDC_IDX_INTLINE: if (!cbe_s[0]) intline_d = ad_s[7:0];
							default: ;
						endcase
					end
				end
			end
			T_FWD: begin
				if (!irdy_s) begin
					t_d = T_FWAIT;
					fwd_req_d = 1'b1;
					fwd_write_d = lop_q[0];
					fwd_io_d = (lop_q != OP_MEM_RD);
					fwd_wdata_d = ad_s;
					fwd_be_d = ~cbe_s;
				end
			end
			T_FWAIT: begin
				if (fwd_ack) begin
					t_d = T_END;
					trdy_d = 1'b1;
					stop_d = !frame_s;
					t_ad = fwd_rdata;
					t_ad_en = !fwd_write_q;
				end
			end
			T_END: begin
				// Trdy lasts one cycle, so wait for it to be gone, not for it to be present.
				if (frame_s && irdy_s && trdy_n_out) begin
					t_d = T_IDLE;
				end
			end
			default: t_d = T_IDLE;
		endcase
		claim_d = (t_d != T_IDLE);
		if (!hw_s) begin
			ctrl_d = 3'h0;
			iobar_d = '0;
			membar_d = '0;
			intline_d = 8'h00;
		end
	end

	// Initiator side.
	pcdc_op_t mop_q, mop_d;
	logic [31:0] maddr_q, maddr_d, mwdata_q, mwdata_d, mrdata_q, mrdata_d, m_ad;
	logic [7:0] mcnt_q, mcnt_d;
	logic m_ad_en, mdone_d, merr_d;
	wire op_legal = (mst_op == OP_MEM_RD_MULT) || (mst_op == OP_MEM_RD_LINE) ||
		(mst_op == OP_MEM_RD) || (mst_op == OP_MEM_WR);
	always_comb begin
		m_d = m_q;
		mop_d = mop_q;
		maddr_d = maddr_q;
		mwdata_d = mwdata_q;
		mrdata_d = mrdata_q;
		mcnt_d = mcnt_q;
		mdone_d = 1'b0;
		merr_d = 1'b0;
		m_ad = maddr_q;
		m_ad_en = 1'b0;
		unique case (m_q)
			M_IDLE: begin
				if (mst_start) begin
					if (op_legal && ctrl_q[`PCDC_CTRL_MST_EN]) begin
						m_d = M_REQ;
						mop_d = mst_op;
						maddr_d = mst_addr;
						mwdata_d = mst_wdata;
					end else begin
						mdone_d = 1'b1;
						merr_d = 1'b1;
					end
				end
			end
			M_REQ: begin
				if (!gnt_s && frame_s && irdy_s && t_q == T_IDLE) begin
					m_d = M_ADDR;
					m_ad_en = 1'b1;
				end
			end
			M_ADDR: begin
				m_d = M_DATA;
				mcnt_d = 8'h00;
				m_ad = mwdata_q;
				m_ad_en = (mop_q == OP_MEM_WR);
			end
			M_DATA: begin
				m_ad = mwdata_q;
				m_ad_en = (mop_q == OP_MEM_WR);
				mcnt_d = mcnt_q + 8'h01;
				if (!trdy_s && !devsel_s) begin
					m_d = M_END;
					mrdata_d = ad_s;
					mdone_d = 1'b1;
					m_ad_en = 1'b0;
				end else if (mcnt_q == 8'(ABORT_CYC - 1)) begin
					// No target answered: end the cycle ourselves and report it.
					m_d = M_END;
					mdone_d = 1'b1;
					merr_d = 1'b1;
					m_ad_en = 1'b0;
				end
			end
			M_END: m_d = M_IDLE;
			default: m_d = M_IDLE;
		endcase
	end

	logic t_drive_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			t_q <= T_IDLE;
			m_q <= M_IDLE;
			lop_q <= 4'h0;
			laddr_q <= 32'h0000_0000;
			ctrl_q <= 3'(`PCDC_CFG_RESET);
			iobar_q <= '0;
			membar_q <= '0;
			intline_q <= 8'h00;
			fwd_req_q <= 1'b0;
			fwd_write_q <= 1'b0;
			fwd_io_q <= 1'b0;
			fwd_wdata_q <= 32'h0000_0000;
			fwd_be_q <= 4'h0;
			mop_q <= OP_MEM_RD;
			maddr_q <= 32'h0000_0000;
			mwdata_q <= 32'h0000_0000;
			mrdata_q <= 32'h0000_0000;
			mcnt_q <= 8'h00;
			mst_done <= 1'b0;
			mst_error <= 1'b0;
			mst_busy <= 1'b0;
			ad_out <= 32'h0000_0000;
			ad_oe <= 1'b0;
			cbe_n_out <= 4'hf;
			cbe_oe <= 1'b0;
			frame_n_out <= 1'b1;
			frame_oe <= 1'b0;
			irdy_n_out <= 1'b1;
			irdy_oe <= 1'b0;
			trdy_n_out <= 1'b1;
			trdy_oe <= 1'b0;
			devsel_n_out <= 1'b1;
			devsel_oe <= 1'b0;
			stop_n_out <= 1'b1;
			stop_oe <= 1'b0;
			req_n <= 1'b1;
			t_drive_q <= 1'b0;
		end else begin
			t_q <= t_d;
			m_q <= m_d;
			lop_q <= lop_d;
			laddr_q <= laddr_d;
			ctrl_q <= ctrl_d;
			iobar_q <= iobar_d;
			membar_q <= membar_d;
			intline_q <= intline_d;
			fwd_req_q <= fwd_req_d;
			fwd_write_q <= fwd_write_d;
			fwd_io_q <= fwd_io_d;
			fwd_wdata_q <= fwd_wdata_d;
			fwd_be_q <= fwd_be_d;
			mop_q <= mop_d;
			maddr_q <= maddr_d;
			mwdata_q <= mwdata_d;
			mrdata_q <= mrdata_d;
			mcnt_q <= mcnt_d;
			mst_done <= mdone_d;
			mst_error <= merr_d;
			mst_busy <= (m_d != M_IDLE);
			ad_out <= t_ad_en ? t_ad : m_ad;
			ad_oe <= t_ad_en || m_ad_en;
			t_drive_q <= t_ad_en;
			cbe_n_out <= (m_d == M_ADDR) ? mop_d : 4'h0;
			cbe_oe <= (m_d == M_ADDR) || (m_d == M_DATA);
			frame_n_out <= !(m_d == M_ADDR);
			frame_oe <= (m_d == M_ADDR) || (m_d == M_DATA);
			irdy_n_out <= !(m_d == M_DATA);
			irdy_oe <= (m_d == M_DATA);
			trdy_n_out <= !trdy_d;
			trdy_oe <= claim_d;
			devsel_n_out <= !claim_d;
			devsel_oe <= claim_d;
			stop_n_out <= !stop_d;
			stop_oe <= claim_d;
			req_n <= !(m_d == M_REQ);
		end
	end
	assign fwd_req = fwd_req_q;
	assign fwd_write = fwd_write_q;
	assign fwd_is_io = fwd_io_q;
	assign fwd_addr = laddr_q;
	assign fwd_wdata = fwd_wdata_q;
	assign fwd_be = fwd_be_q;
	assign mst_rdata = mrdata_q;
	assign enables = ctrl_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_tgt_ops;
		$rose(devsel_oe) |-> (lop_q inside {OP_IO_RD, OP_IO_WR, OP_MEM_RD, OP_CFG_RD, OP_CFG_WR});
	endproperty
	a_tgt_ops: assert property (p_tgt_ops) else $error("claimed illegal op");
	property p_mst_ops;
		$fell(frame_n_out) |-> (cbe_n_out inside {OP_MEM_RD_MULT, OP_MEM_RD_LINE, OP_MEM_RD, OP_MEM_WR});
	endproperty
	a_mst_ops: assert property (p_mst_ops) else $error("issued illegal op");
	property p_one_role;
		!(devsel_oe && frame_oe);
	endproperty
	a_one_role: assert property (p_one_role) else $error("both roles at once");
	property p_type0;
		$rose(devsel_oe) && lop_q[3:1] == 3'b101 |-> laddr_q[1:0] == 2'b00;
	endproperty
	a_type0: assert property (p_type0) else $error("type 1 cycle claimed");
	property p_out_range;
		(t_q == T_CFG) && !irdy_s && laddr_q[7:6] != 2'b00 |=>
			$stable(ctrl_q) && $stable(iobar_q) && $stable(membar_q) && $stable(intline_q) &&
			(lop_q[0] ? !ad_oe : (ad_out == 32'h0000_0000));
	endproperty
	a_out_range: assert property (p_out_range) else $error("out of range access acted");
	property p_hw_clear;
		!hw_s |=> ctrl_q == 3'h0 && iobar_q == '0 && membar_q == '0 && intline_q == 8'h00;
	endproperty
	a_hw_clear: assert property (p_hw_clear) else $error("hardware reset left bits");
	property p_disabled;
		$rose(devsel_oe) && (($past(ctrl_q) & 3'b011) == 3'b000) |-> lop_q[3:1] == 3'b101;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled device claimed");
	property p_req;
		(m_q == M_REQ) |-> !req_n ##0 (m_q == M_REQ) [*1] ##1 (!req_n || m_q != M_REQ);
	endproperty
	a_req: assert property (p_req) else $error("request missing");
	property p_grant;
		$fell(frame_n_out) |-> !$past(gnt_s);
	endproperty
	a_grant: assert property (p_grant) else $error("started without grant");
	c_cfg_read: cover property ($rose(devsel_oe) ##[1:20] (t_drive_q && lop_q == OP_CFG_RD));
	c_fwd: cover property (fwd_req ##[1:20] !trdy_n_out);
	c_mst_ok: cover property (mst_done && !mst_error);
	c_mst_abort: cover property (mst_done && mst_error && mcnt_q != 8'h00);
endmodule

// ### src/pcdc_cfg.svh
`ifndef PCDC_CFG_SVH
`define PCDC_CFG_SVH
`define PCDC_IDX_ID 4'h0
`define PCDC_IDX_CTRL 4'h1
`define PCDC_IDX_CLASS 4'h2
`define PCDC_IDX_IOBAR 4'h4
`define PCDC_IDX_MEMBAR 4'h5
`define PCDC_IDX_INTLINE 4'hf
`define PCDC_CTRL_IO_EN 0
`define PCDC_CTRL_MEM_EN 1
`define PCDC_CTRL_MST_EN 2
`define PCDC_IOBAR_LSB 4
`define PCDC_MEMBAR_LSB 12
`define PCDC_CFG_RESET 32'h0000_0000
`define PCDC_ABORT_NS 200
`define PCDC_CLK_NS 10
`define PCDC_ABORT_CYC ((`PCDC_ABORT_NS) / (`PCDC_CLK_NS))
`endif

// ### src/pcdc_pkg.sv
package pcdc_pkg;
	typedef enum logic [3:0] {
		OP_IO_RD = 4'h2,
		OP_IO_WR = 4'h3,
		OP_MEM_RD = 4'h6,
		OP_MEM_WR = 4'h7,
		OP_CFG_RD = 4'ha,
		OP_CFG_WR = 4'hb,
		OP_MEM_RD_MULT = 4'hc,
		OP_MEM_RD_LINE = 4'he
	} pcdc_op_t;
	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_CFG = 3'b001,
		T_FWD = 3'b010,
		T_FWAIT = 3'b011,
		T_END = 3'b100
	} pcdc_tst_t;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_REQ = 3'b001,
		M_ADDR = 3'b010,
		M_DATA = 3'b011,
		M_END = 3'b100
	} pcdc_mst_t;
endpackage

// ### bench/pcdc_host_model.sv
`timescale 1ns/1ps
module pcdc_host_model (
	input wire logic clk,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic trdy_n,
	input wire logic devsel_n,
	input wire logic req_n,
	output logic [31:0] ad_h,
	output logic [3:0] cbe_h,
	output logic frame_h,
	output logic irdy_h,
	output logic trdy_h,
	output logic devsel_h,
	output logic idsel,
	output logic gnt_n
);
	logic [31:0] hd, td, junk, wd;
	logic hen, ten, hm, act, mute, early;
	logic [3:0] op;
	int dly, gdly, cnt, gc;
	// A released bus shows a moving pattern, so a stale value never passes for data.
	assign ad_h = hen ? hd : (ten ? td : junk);
	initial begin
		{hd, td, wd} = '0;
		junk = 32'h0f1e_2d3c;
		{hen, ten, hm, act, mute, early, idsel} = '0;
		{frame_h, irdy_h, trdy_h, devsel_h, gnt_n} = '1;
		cbe_h = 4'hf;
		op = 4'h0;
		{dly, gdly, cnt, gc} = '0;
	end
	always @(posedge clk) begin
		junk <= {junk[30:0], ~junk[31]};
		gc <= req_n ? 0 : gc + 1;
		gnt_n <= req_n || gc < gdly;
		trdy_h <= 1'b1;
		devsel_h <= 1'b1;
		ten <= 1'b0;
		if (!trdy_n && !irdy_n && !hm)
			wd <= ad;
		if (!hm && !frame_n && irdy_n && !act) begin
			op <= cbe_n;
			act <= !mute;
			cnt <= 0;
			early <= early | gnt_n;
		end else if (act && !irdy_n) begin
			cnt <= cnt + 1;
			if (cnt == dly) begin
				trdy_h <= 1'b0;
				devsel_h <= 1'b0;
				ten <= 1'b1;
				td <= {28'h5a0_0000, op};
				act <= 1'b0;
			end
		end
	end
	task automatic cyc(input logic [3:0] cmd, input logic [31:0] adr, input logic sel,
			input logic [3:0] be, input logic [31:0] wdat, output logic [31:0] rd,
			output logic hit);
		hm = 1'b1;
		hit = 1'b0;
		frame_h <= 1'b0;
		hen <= 1'b1;
		hd <= adr;
		cbe_h <= cmd;
		idsel <= sel;
		@(posedge clk);
		frame_h <= 1'b1;
		irdy_h <= 1'b0;
		cbe_h <= ~be;
		hen <= cmd[0];
		hd <= wdat;
		idsel <= 1'b0;
		for (int n = 0; n < 16; n++) begin
			@(negedge clk);
			hit = hit | ~devsel_n;
			if (!trdy_n)
				break;
		end
		rd = ad;
		@(posedge clk);
		irdy_h <= 1'b1;
		hen <= 1'b0;
		cbe_h <= 4'hf;
		repeat (3) @(posedge clk);
		hm = 1'b0;
	endtask
endmodule

// ### bench/pci_cycle_decode_and_config_space_tb.sv
`timescale 1ns/1ps
module pci_cycle_decode_and_config_space_tb;
	import pcdc_pkg::*;
	logic clk, reset, hardware_reset_in_n, idsel, gnt_n, req_n, hit, err;
	logic [31:0] ad, ad_out, ad_h, fwd_addr, fwd_wdata, mst_addr, mst_wdata, mst_rdata, rd;
	logic [3:0] cbe_n, cbe_n_out, cbe_h, fwd_be;
	logic frame_n, frame_n_out, frame_h, irdy_n, irdy_n_out, irdy_h;
	logic trdy_n, trdy_n_out, trdy_h, devsel_n, devsel_n_out, devsel_h;
	logic ad_oe, cbe_oe, frame_oe, irdy_oe, trdy_oe, devsel_oe;
	logic fwd_req, fwd_write, fwd_is_io, mst_start, mst_busy, mst_done, mst_error;
	logic fwd_ack = 1'b0;
	logic [31:0] fwd_rdata = 32'h0;
	logic [2:0] enables;
	logic stop_n_out, stop_oe, bsy;
	pcdc_op_t mst_op;
	int n_mismatch = 0;
	int checked = 0;
	int cyc_n = 0;
	assign ad = ad_oe ? ad_out : ad_h;
	assign cbe_n = cbe_oe ? cbe_n_out : cbe_h;
	assign frame_n = frame_oe ? frame_n_out : frame_h;
	assign irdy_n = irdy_oe ? irdy_n_out : irdy_h;
	assign trdy_n = trdy_oe ? trdy_n_out : trdy_h;
	assign devsel_n = devsel_oe ? devsel_n_out : devsel_h;
	pcdc_top #(.CLASS_BASE(8'h01), .CLASS_SUB(8'h80), .CLASS_PROGIF(8'h8a), .REVISION(8'h07)) dut_u (
		.clk, .reset, .hardware_reset_in_n, .ad_in(ad), .ad_out, .ad_oe, .cbe_n_in(cbe_n),
		.cbe_n_out, .cbe_oe, .frame_n_in(frame_n), .frame_n_out, .frame_oe, .irdy_n_in(irdy_n),
		.irdy_n_out, .irdy_oe, .trdy_n_in(trdy_n), .trdy_n_out, .trdy_oe,
		.devsel_n_in(devsel_n), .devsel_n_out, .devsel_oe, .stop_n_out, .stop_oe, .idsel,
		.gnt_n, .req_n, .fwd_req, .fwd_write, .fwd_is_io, .fwd_addr, .fwd_wdata, .fwd_be,
		.fwd_ack, .fwd_rdata, .mst_start, .mst_op, .mst_addr, .mst_wdata, .mst_busy,
		.mst_done, .mst_error, .mst_rdata, .enables);
	pcdc_host_model host_u (.clk, .ad, .cbe_n, .frame_n, .irdy_n, .trdy_n, .devsel_n, .req_n,
		.ad_h, .cbe_h, .frame_h, .irdy_h, .trdy_h, .devsel_h, .idsel, .gnt_n);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// The disk side answers one cycle after each forwarded request.
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		fwd_ack <= fwd_req;
		fwd_rdata <= fwd_addr ^ 32'h0f0f_0000;
		if (cyc_n == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	always @(negedge clk)
		if (((frame_oe | irdy_oe) & (devsel_oe | trdy_oe)) === 1'b1)
			chk(32'h1, 32'h0);
	// The host never bursts, so every target data phase must end without a disconnect.
	always @(negedge clk)
		if (trdy_oe === 1'b1 && trdy_n_out === 1'b0)
			chk({30'h0, stop_oe, stop_n_out}, 32'h3);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("mismatches %0d, comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic hc(input logic [3:0] c, input logic [31:0] a, input logic s,
			input logic [3:0] be, input logic [31:0] d);
		host_u.cyc(c, a, s, be, d, rd, hit);
	endtask
	task automatic cfgw(input logic [5:0] i, input logic [31:0] d, input logic [3:0] be);
		hc(4'hb, {24'h0, i, 2'b00}, 1'b1, be, d);
	endtask
	task automatic cfgr(input logic [5:0] i);
		hc(4'ha, {24'h0, i, 2'b00}, 1'b1, 4'hf, 32'h0);
	endtask
	task automatic mst(input logic [3:0] op);
		mst_start <= 1'b1;
		mst_op <= pcdc_op_t'(op);
		mst_addr <= 32'h2000_0040;
		mst_wdata <= 32'h1357_9bdf;
		@(posedge clk);
		mst_start <= 1'b0;
		for (int n = 0; n < 100; n++) begin
			@(negedge clk);
			if (n == 0)
				bsy = mst_busy;
			if (mst_done === 1'b1)
				break;
		end
		rd = mst_rdata;
		err = mst_done === 1'b1 ? mst_error : 1'bx;
		repeat (3) @(posedge clk);
	endtask
	task automatic t_reset();
		chk({29'h0, enables}, 32'h0);
		cfgr(6'd2);
		chk(rd, 32'h0180_8a07);
		hc(4'h2, 32'h0, 1'b0, 4'hf, 32'h0);
		chk({31'h0, hit}, 32'h0);
	endtask
	task automatic t_cfg();
		cfgw(6'd15, 32'hffff_ffa5, 4'hf);
		cfgr(6'd15);
		chk(rd, 32'h0000_00a5);
		cfgw(6'd17, 32'h0000_0007, 4'hf);
		chk({29'h0, enables}, 32'h0);
		cfgr(6'd17);
		chk(rd, 32'h0);
		cfgw(6'd3, 32'hffff_ffff, 4'hf);
		cfgr(6'd3);
		chk(rd, 32'h0);
		cfgw(6'd4, 32'hdead_1230, 4'h3);
		cfgw(6'd4, 32'h0, 4'hc);
		cfgr(6'd4);
		chk(rd, 32'h0000_1231);
		hc(4'hb, 32'h0000_003d, 1'b1, 4'hf, 32'h0);
		chk({31'h0, hit}, 32'h0);
	endtask
	task automatic t_target();
		logic [3:0] bad [5] = '{4'h7, 4'hc, 4'he, 4'hf, 4'h1};
		cfgw(6'd1, 32'h0000_0007, 4'hf);
		chk({29'h0, enables}, 32'h7);
		cfgw(6'd5, 32'h8000_0000, 4'hf);
		hc(4'h2, 32'h0000_1234, 1'b0, 4'hf, 32'h0);
		chk(rd, 32'h0f0f_1234);
		chk({30'h0, fwd_write, fwd_is_io}, 32'h1);
		hc(4'h3, 32'h0000_1238, 1'b0, 4'h5, 32'h2468_ace0);
		chk(fwd_wdata, 32'h2468_ace0);
		chk({28'h0, fwd_be}, 32'h5);
		chk({30'h0, fwd_write, fwd_is_io}, 32'h3);
		hc(4'h6, 32'h8000_0010, 1'b0, 4'hf, 32'h0);
		chk(rd, 32'h8f0f_0010);
		chk({30'h0, fwd_write, fwd_is_io}, 32'h0);
		foreach (bad[i]) begin
			hc(bad[i], 32'h8000_0020, 1'b0, 4'hf, 32'h0);
			chk({31'h0, hit}, 32'h0);
		end
		hc(4'ha, 32'h0000_0004, 1'b0, 4'hf, 32'h0);
		chk({31'h0, hit}, 32'h0);
	endtask
	task automatic t_master();
		logic [3:0] ops [4] = '{4'h6, 4'h7, 4'hc, 4'he};
		foreach (ops[i]) begin
			host_u.gdly = i * 3;
			host_u.dly = i;
			mst(ops[i]);
			chk({31'h0, err}, 32'h0);
			chk({31'h0, bsy}, 32'h1);
			chk({28'h0, host_u.op}, {28'h0, ops[i]});
			chk(ops[i][0] ? host_u.wd : rd, ops[i][0] ? 32'h1357_9bdf : {28'h5a0_0000, ops[i]});
		end
		chk({31'h0, host_u.early}, 32'h0);
		host_u.mute = 1'b1;
		mst(4'h6);
		chk({31'h0, err}, 32'h1);
		chk({31'h0, mst_busy}, 32'h0);
		host_u.mute = 1'b0;
		mst(4'h2);
		chk({31'h0, err}, 32'h1);
		chk({31'h0, bsy}, 32'h0);
	endtask
	task automatic t_hwrst();
		hardware_reset_in_n <= 1'b0;
		repeat (4) @(posedge clk);
		hardware_reset_in_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk({29'h0, enables}, 32'h0);
		cfgr(6'd15);
		chk(rd, 32'h0);
		cfgr(6'd4);
		chk(rd, 32'h0000_0001);
		mst(4'h7);
		chk({31'h0, err}, 32'h1);
		hc(4'h2, 32'h0000_1234, 1'b0, 4'hf, 32'h0);
		chk({31'h0, hit}, 32'h0);
	endtask
	initial begin
		reset = 1'b1;
		hardware_reset_in_n = 1'b1;
		mst_start = 1'b0;
		mst_op = OP_MEM_RD;
		mst_addr = 32'h0;
		mst_wdata = 32'h0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_cfg();
		t_target();
		t_master();
		t_hwrst();
		end_sim();
	end
endmodule
